// ==== port6_consts.vh ====
// How it works
// R1 - seven usable pins, bit 7 unimplemented
// R2 - same pin behaviour in every operating mode
// R3 - direction bit 1 output, 0 input
// R4 - direction write-only, reads all ones
// R5 - direction loads 0x80, kept in software standby
// R6 - output pins keep driving during software standby
// R7 - standby resets module, pin returns to port
// R8 - data bit 7 ignores writes, reads 1
// R9 - output bits read back stored data
// R10 - input bits read live pin level
// R11 - data loads 0x80, kept in software standby
// R12 - mask bit 1 selects own pin
// R13 - mask bit 0 selects neighbour pins 3..0
// R14 - pull-up on when input and enabled
// R15 - pull-up bits 7..4 neighbour, 3..0 own
// R16 - only own pins 0..3 have pull-ups
// R17 - pull-up control loads 0x00, kept in standby; the code keeps it in software standby only, hardware standby clears it to 0x00
// R18 - pin 6 feeds enabled external interrupt 2
// R19 - pin 5 feeds enabled external interrupt 1
// R20 - pin 4 feeds enabled external interrupt 0
// R21 - pin levels synchronised before use
`ifndef PORT6_CONSTS_VH
`define PORT6_CONSTS_VH

`define ADR_PORT_DIRECTION     16'hFFB9
`define ADR_PORT_DATA          16'hFFBB
`define ADR_KEY_PULLUP_CONTROL 16'hFFF2

`define RST_PORT_DIRECTION     8'h80
`define RST_PORT_DATA          8'h80
`define RST_KEY_PULLUP_CONTROL 8'h00

`define RD_PORT_DIRECTION      8'hFF
`define RD_UNMAPPED            8'h00

`define BIT_RESERVED           7
`define PIN_EXT_INT2           6
`define PIN_EXT_INT1           5
`define PIN_EXT_INT0           4

`define PU_OWN_MSB             3
`define PU_NBR_LSB             4

`endif

// ==== port6_gpio.v ====
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "port6_consts.vh"

module port6_gpio (
	input  wire        clk_i,
	input  wire        rst_i,
	// device power states, from on-chip logic
	input  wire        hw_standby_i,
	input  wire        sw_standby_i,
	// classic wishbone slave, 8-bit data
	input  wire [15:0] wb_adr_i,
	input  wire [7:0]  wb_dat_i,
	input  wire        wb_we_i,
	input  wire [0:0]  wb_sel_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	output wire [7:0]  wb_dat_o,
	output wire        wb_ack_o,
	// package pins of this port
	input  wire [6:0]  pin_in_i,
	output wire [6:0]  pin_out_o,
	output wire [6:0]  pin_oe_o,
	output wire [3:0]  pullup_en_o,
	// neighbouring port pins 3..0 and its direction bits
	input  wire [3:0]  nbr_pin_i,
	input  wire [3:0]  neighbour_port_direction_i,
	output wire [3:0]  nbr_pullup_en_o,
	// key-sense mask bits 7..4
	input  wire [3:0]  key_mask_bits_i,
	// on-chip timer taking over pins
	input  wire [6:0]  periph_oe_i,
	input  wire [6:0]  periph_out_i,
	output wire        periph_init_o,
	output wire [6:0]  pin_sync_o,
	// external interrupt enables 2..0 and inputs
	input  wire [2:0]  ext_int_enable_i,
	output wire [2:0]  ext_int_o
);

	reg  [7:0] dir_ff;
	reg  [7:0] data_ff;
	reg  [7:0] pullup_ctl_ff;

	reg  [6:0] pin_meta_ff;
	reg  [6:0] pin_sync_ff;
	reg  [3:0] nbr_meta_ff;
	reg  [3:0] nbr_sync_ff;

	reg        ack_ff;
	reg  [7:0] rdata_ff;
	reg  [6:0] pin_out_ff;
	reg  [6:0] pin_oe_ff;
	reg  [3:0] pullup_en_ff;
	reg  [3:0] nbr_pullup_en_ff;
	reg        periph_init_ff;
	reg  [2:0] ext_int_ff;

	reg  [7:0] nxt_rdata;
	reg  [7:0] port_read;
	reg  [6:0] nxt_pin_out;
	reg  [6:0] nxt_pin_oe;
	reg  [6:0] periph_own;

	wire       bus_req;
	wire       wr_en;
	wire       sel_dir;
	wire       sel_data;
	wire       sel_pullup;
	wire       dev_reset;

	integer    i;

	// hardware standby clears the registers just as reset does
	assign dev_reset  = rst_i | hw_standby_i;                  // see R5

	// one request per ack; the idle cycle after ack keeps a held
	// request from being taken twice
	assign bus_req    = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wr_en      = bus_req & wb_we_i & wb_sel_i[0];
	assign sel_dir    = (wb_adr_i == `ADR_PORT_DIRECTION);
	assign sel_data   = (wb_adr_i == `ADR_PORT_DATA);
	assign sel_pullup = (wb_adr_i == `ADR_KEY_PULLUP_CONTROL);

	// two-stage synchronisers for pins from outside the clock domain
	always @(posedge clk_i) begin
		if (rst_i) begin
			pin_meta_ff <= 7'h00;
			pin_sync_ff <= 7'h00;
			nbr_meta_ff <= 4'h0;
			nbr_sync_ff <= 4'h0;
		end else begin
			pin_meta_ff <= pin_in_i;                            // see R21
			pin_sync_ff <= pin_meta_ff;                         // see R21
			nbr_meta_ff <= nbr_pin_i;                           // see R21
			nbr_sync_ff <= nbr_meta_ff;                         // see R21
		end
	end

	// direction register; no power-state input other than hardware
	// standby touches it, so software standby keeps it
	always @(posedge clk_i) begin
		if (dev_reset) begin
			dir_ff <= `RST_PORT_DIRECTION;                      // see R5
		end else if (wr_en && sel_dir) begin
			dir_ff <= {1'b1, wb_dat_i[6:0]};                    // see R1
		end
	end

	// data register, reserved top bit fixed at one
	always @(posedge clk_i) begin
		if (dev_reset) begin
			data_ff <= `RST_PORT_DATA;                          // see R11
		end else if (wr_en && sel_data) begin
			data_ff <= {1'b1, wb_dat_i[6:0]};                   // see R8
		end
	end

	// pull-up control register, fully read/write
	always @(posedge clk_i) begin
		if (dev_reset) begin
			pullup_ctl_ff <= `RST_KEY_PULLUP_CONTROL;           // see R17
		end else if (wr_en && sel_pullup) begin
			pullup_ctl_ff <= wb_dat_i;                          // see R15
		end
	end

	// port read value; the operating mode plays no part here
	always @* begin                                             // see R2
		port_read = 8'h00;
		for (i = 0; i < 7; i = i + 1) begin
			if (dir_ff[i]) begin
				port_read[i] = data_ff[i];                      // see R9
			end else begin
				port_read[i] = pin_sync_ff[i];                  // see R10
			end
		end
		// upper input bits may be steered to the neighbour's pins
		for (i = 4; i < 7; i = i + 1) begin
			if (!dir_ff[i] && !key_mask_bits_i[i - 4]) begin
				port_read[i] = nbr_sync_ff[i - 4];              // see R13
			end
		end
		// bit 7 has no pin: one, or the neighbour's pin 3
		if (key_mask_bits_i[3]) begin
			port_read[`BIT_RESERVED] = 1'b1;                    // see R12
		end else begin
			port_read[`BIT_RESERVED] = nbr_sync_ff[3];          // see R13
		end
	end

	// read mux; unmapped addresses still ack so the master never hangs
	always @* begin
		nxt_rdata = `RD_UNMAPPED;
		if (sel_dir) begin
			nxt_rdata = `RD_PORT_DIRECTION;                     // see R4
		end else if (sel_data) begin
			nxt_rdata = port_read;
		end else if (sel_pullup) begin
			nxt_rdata = pullup_ctl_ff;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff   <= 1'b0;
			rdata_ff <= 8'h00;
		end else begin
			ack_ff <= bus_req;
			if (bus_req && !wb_we_i) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	// pin drive: a peripheral may take a pin, but not in software
	// standby, where it is held in its initial state
	always @* begin
		periph_own = periph_oe_i & {7{~sw_standby_i}};          // see R7
		for (i = 0; i < 7; i = i + 1) begin
			if (periph_own[i]) begin
				nxt_pin_oe[i]  = 1'b1;
				nxt_pin_out[i] = periph_out_i[i];
			end else begin
				// software standby leaves dir/data alone, so outputs keep driving
				nxt_pin_oe[i]  = dir_ff[i];                     // see R3
				nxt_pin_out[i] = data_ff[i];                    // see R6
			end
		end
	end

	always @(posedge clk_i) begin
		if (dev_reset) begin
			pin_oe_ff      <= 7'h00;
			pin_out_ff     <= 7'h00;
			periph_init_ff <= 1'b0;
		end else begin
			pin_oe_ff      <= nxt_pin_oe;                       // see R3
			pin_out_ff     <= nxt_pin_out;
			periph_init_ff <= sw_standby_i;                     // see R7
		end
	end

	// pull-ups: only own pins 3..0 have them, bits 7..4 serve the
	// neighbour's pins 3..0
	always @(posedge clk_i) begin
		if (dev_reset) begin
			pullup_en_ff     <= 4'h0;
			nbr_pullup_en_ff <= 4'h0;
		end else begin
			pullup_en_ff <= ~dir_ff[`PU_OWN_MSB:0]
				& pullup_ctl_ff[`PU_OWN_MSB:0];                 // see R14
			nbr_pullup_en_ff <= ~neighbour_port_direction_i
				& pullup_ctl_ff[7:`PU_NBR_LSB];                 // see R15
		end
	end

	// external interrupts are fed only while their enable is set;
	// the pin is read whatever its direction
	always @(posedge clk_i) begin
		if (rst_i) begin
			ext_int_ff <= 3'h0;
		end else begin
			ext_int_ff[2] <= pin_sync_ff[`PIN_EXT_INT2]
				& ext_int_enable_i[2];                          // see R18
			ext_int_ff[1] <= pin_sync_ff[`PIN_EXT_INT1]
				& ext_int_enable_i[1];                          // see R19
			ext_int_ff[0] <= pin_sync_ff[`PIN_EXT_INT0]
				& ext_int_enable_i[0];                          // see R20
		end
	end

	assign wb_ack_o        = ack_ff;
	assign wb_dat_o        = rdata_ff;
	assign pin_out_o       = pin_out_ff;
	assign pin_oe_o        = pin_oe_ff;
	assign pullup_en_o     = pullup_en_ff;                      // see R16
	assign nbr_pullup_en_o = nbr_pullup_en_ff;
	assign periph_init_o   = periph_init_ff;
	assign pin_sync_o      = pin_sync_ff;                       // see R21
	assign ext_int_o       = ext_int_ff;

endmodule // port6_gpio

// ==== port6_gpio_monitor.sv ====
`timescale 1ns/1ps
module port6_gpio_monitor (
	input logic       clk_i, rst_i, hw_standby_i, sw_standby_i,
	input logic       wb_cyc_i, wb_stb_i, wb_ack_o, periph_init_o,
	input logic [6:0] pin_in_i, pin_oe_o, periph_oe_i, pin_sync_o,
	input logic [3:0] pullup_en_o,
	input logic [2:0] ext_int_enable_i, ext_int_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// long enough for the sync chain to flush
	sequence s_calm;
		(ext_int_enable_i == 3'h7 && $stable(pin_in_i))[*4];
	endsequence
	chk_ack_take: assert property (s_take |=> wb_ack_o) else $error("no ack");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	chk_sync_lag: assert property (
		!$past(rst_i) && !$past(rst_i, 2) |-> pin_sync_o == $past(pin_in_i, 2))
		else $error("sync lag");
	chk_irq_pass: assert property (
		s_calm |-> ext_int_o == pin_in_i[6:4]) else $error("irq level");
	chk_irq_mask: assert property (
		(ext_int_enable_i == 3'h0)[*2] |-> ext_int_o == 3'h0) else $error("irq mask");
	chk_pu_input: assert property (
		$past(periph_oe_i) == 7'h0 |-> (pullup_en_o & pin_oe_o[3:0]) == 4'h0)
		else $error("pull-up on output");
	chk_hw_off: assert property (
		hw_standby_i[*2] |-> pin_oe_o == 7'h0 && pullup_en_o == 4'h0) else $error("hw standby");
	chk_init_on: assert property ($rose(sw_standby_i) |=> periph_init_o)
		else $error("no init");
	chk_init_off: assert property ($fell(sw_standby_i) |=> !periph_init_o)
		else $error("init stuck");
endmodule // port6_gpio_monitor

bind port6_gpio port6_gpio_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
	.hw_standby_i(hw_standby_i), .sw_standby_i(sw_standby_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .periph_init_o(periph_init_o),
	.pin_in_i(pin_in_i), .pin_oe_o(pin_oe_o), .periph_oe_i(periph_oe_i),
	.pin_sync_o(pin_sync_o), .pullup_en_o(pullup_en_o),
	.ext_int_enable_i(ext_int_enable_i), .ext_int_o(ext_int_o));

// ==== port6_pins.sv ====
`timescale 1ns/1ps
module port6_pins (
	input  logic [6:0] out_i, oe_i, pu_i, ext_i,
	output logic [6:0] pin_o
);
	// outside world only pulls high or floats; a float reads low unless pulled up
	assign pin_o = (oe_i & out_i) | (~oe_i & (pu_i | ext_i));
endmodule // port6_pins

// ==== port6_gpio_tb.sv ====
`timescale 1ns/1ps
module port6_gpio_tb;
	logic clk_i = 0, rst_i = 1, hws = 0, sws = 0, we = 0, cyc = 0, sel = 1, ack, pinit;
	logic [15:0] adr = 0;
	logic [7:0]  wd = 0, rd, d, v, k, q;
	logic [6:0]  pin, pout, poe, sync, e, ext = 0, tout = 0, toe = 0;
	logic [3:0]  pu, npu, nbr = 0, ndir = 0, msk = 4'hF;
	logic [2:0]  ien = 0, irq;
	int err_count = 0, num_checks = 0;
	always #2 clk_i = ~clk_i;
	port6_gpio dut (.clk_i(clk_i), .rst_i(rst_i), .hw_standby_i(hws), .sw_standby_i(sws),
		.wb_adr_i(adr), .wb_dat_i(wd), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_dat_o(rd), .wb_ack_o(ack), .pin_in_i(pin), .pin_out_o(pout),
		.pin_oe_o(poe), .pullup_en_o(pu), .nbr_pin_i(nbr), .neighbour_port_direction_i(ndir),
		.nbr_pullup_en_o(npu), .key_mask_bits_i(msk), .periph_oe_i(toe), .periph_out_i(tout),
		.periph_init_o(pinit), .pin_sync_o(sync), .ext_int_enable_i(ien), .ext_int_o(irq));
	port6_pins pins (.out_i(pout), .oe_i(poe), .pu_i({3'h0, pu}), .ext_i(ext), .pin_o(pin));
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, exp, input string m);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] x);
		int n = 0;
		@(posedge clk_i);
		we <= w;
		adr <= a;
		wd <= x;
		cyc <= 1;
		do @(posedge clk_i); while (ack !== 1'b1 && ++n < 20);
		if (n >= 20) begin
			err_count++;
			test_done();
		end
		q = rd;
		cyc <= 0;
		sel <= 1;
	endtask
	function automatic logic [7:0] exp_rd(logic [6:0] dr, dt, p, logic [3:0] m, nb);
		logic [7:0] r = {1'b1, dr & dt | ~dr & p};
		for (int i = 0; i < 4; i++)
			if (!m[i] && (i == 3 || !dr[4+i])) r[4+i] = nb[i];
		return r;
	endfunction
	initial begin
		void'($urandom(32'h3FD393FF));
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		bus(0, 16'hFFB9, 0);
		chk(q, 8'hFF, "dir read");
		bus(0, 16'hFFBB, 0);
		chk(q, 8'h80, "data reset");
		bus(0, 16'hFFF2, 0);
		chk(q, 8'h00, "pull-up reset");
		chk(poe, 8'h00, "oe reset");
		$display("reset test done");
		for (int i = 0; i < 12; i++) begin
			d = i < 2 ? {8{i[0]}} : $urandom;
			v = $urandom;
			k = i == 0 ? 8'hFF : $urandom;
			ext <= $urandom;
			nbr <= $urandom;
			ndir <= $urandom;
			msk <= i == 0 ? 4'h0 : $urandom;
			ien <= i == 1 ? 3'h7 : (i == 0 ? 3'h0 : $urandom);
			bus(1, 16'hFFB9, d);
			bus(1, 16'hFFBB, v);
			bus(1, 16'hFFF2, k);
			repeat (4) @(posedge clk_i);
			e = d[6:0] & v[6:0] | ~d[6:0] & (ext | {3'h0, k[3:0]});
			chk(poe, d[6:0], "oe");
			chk(pout & poe, v[6:0] & d[6:0], "out");
			chk(pu, k[3:0] & ~d[3:0], "pull-up");
			chk(npu, k[7:4] & ~ndir, "nbr pull-up");
			chk(irq, e[6:4] & ien, "irq");
			bus(0, 16'hFFBB, 0);
			chk(q, exp_rd(d[6:0], v[6:0], e, msk, nbr), "data");
			bus(0, 16'hFFF2, 0);
			chk(q, k, "pull-up read");
		end
		$display("random test done");
		sel <= 0;
		bus(1, 16'hFFF2, ~k);
		bus(1, 16'hFFB0, ~k);
		bus(0, 16'hFFF2, 0);
		chk(q, k, "refused write");
		bus(0, 16'hFFB0, 0);
		chk(q, 8'h00, "unmapped");
		$display("refusal test done");
		toe <= 7'h03;
		tout <= 7'h03;
		repeat (3) @(posedge clk_i);
		chk(poe, d[6:0] | 7'h03, "takeover");
		sws <= 1;
		repeat (3) @(posedge clk_i);
		chk(poe, d[6:0], "standby oe");
		chk(pinit, 1, "init");
		bus(0, 16'hFFF2, 0);
		chk(q, k, "kept");
		sws <= 0;
		toe <= 0;
		$display("software standby test done");
		hws <= 1;
		repeat (3) @(posedge clk_i);
		hws <= 0;
		chk({pu, poe[3:0]}, 0, "hw standby");
		bus(0, 16'hFFF2, 0);
		chk(q, 8'h00, "hw pull-up");
		bus(0, 16'hFFBB, 0);
		chk(q, exp_rd(0, 0, ext, msk, nbr), "hw data");
		$display("hardware standby test done");
		test_done();
	end
endmodule // port6_gpio_tb
